// ===== logic/rx_hit_pkg.sv
// Constants and carrier types for the receive range-hit sideband.
package rx_hit_pkg;

  localparam int HIT_W       = 8;
  localparam int FUNC_W      = 3;
  localparam int DATA_W      = 64;
  localparam int FIFO_DEPTH  = 32;
  localparam int READY_LAT   = 2;
  localparam int EP_BAR_N    = 6;
  localparam int RP_BAR_N    = 2;

  // Endpoint bit positions.
  localparam int EP_BAR0_BIT = 0;
  localparam int EP_ROM_BIT  = 6;
  localparam int EP_RSVD_BIT = 7;

  // Root port bit positions.
  localparam int RP_BAR0_BIT = 0;
  localparam int RP_PRI_BIT  = 2;
  localparam int RP_SEC_BIT  = 3;
  localparam int RP_BUS_BIT  = 4;
  localparam int RP_IO_BIT   = 5;
  localparam int RP_NP_BIT   = 6;
  localparam int RP_PF_BIT   = 7;

  localparam logic [HIT_W-1:0]  HIT_NONE  = 8'h00;
  localparam logic [FUNC_W-1:0] FUNC_RST  = 3'h0;
  localparam logic              VALID_RST = 1'b0;

  typedef struct packed {
    logic [EP_BAR_N-1:0] ep_bar;
    logic                ep_rom;
    logic [RP_BAR_N-1:0] rp_bar;
    logic                rp_primary_bus;
    logic                rp_secondary_bus;
    logic                rp_bus_window;
    logic                rp_io_window;
    logic                rp_np_window;
    logic                rp_pref_window;
    logic                is_request;
  } range_decode_type;

  typedef struct packed {
    logic              first;
    logic              last;
    logic [HIT_W-1:0]  hit;
    logic [FUNC_W-1:0] func;
  } beat_meta_type;

endpackage

// ===== logic/rx_range_hit.sv
// Receive beat buffer and range-hit sideband output stage.
// What this block does
// - Eight-bit range-hit output beside receive stream.
// - Hit meaningful only for memory/IO requests.
// - Hit valid on the first beat.
// - Endpoint bits 0-5 flag BAR 0-5.
// - Endpoint bit 6 ROM, bit 7 reserved.
// - Root bits 0-1 BARs, 2-3 bus numbers.
// - Root bit 4 bus window, 5 IO.
// - Root bit 6 non-prefetchable, 7 prefetchable.
// - Three-bit function number accompanies hit.
// - Valid drops within two cycles of ready.
`timescale 1ns/10ps

module rx_beat_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = rx_hit_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0]   count;
    logic             wr_ready;
  } fifo_state_type;

  fifo_state_type   st_reg;
  fifo_state_type   st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign push         = wr_valid_in && st_reg.wr_ready;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_valid_out = (st_reg.count != '0);
  assign rd_data_out  = mem[st_reg.rptr];
  assign wr_ready_out = st_reg.wr_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wptr = (st_reg.wptr == PTR_LAST) ? '0 : st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = (st_reg.rptr == PTR_LAST) ? '0 : st_reg.rptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_next.count = st_reg.count + 1'b1;
      2'b01:   st_next.count = st_reg.count - 1'b1;
      default: st_next.count = st_reg.count;
    endcase
    // Ready is registered so the source sees a flop; it is taken from the next
    // count, so no slot is lost: it falls as the last free entry is taken.
    st_next.wr_ready = (st_next.count < CNT_FULL);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg <= '{wptr: '0, rptr: '0, count: '0, wr_ready: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset: only entries below the count are ever read, which saves a wide clear.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[st_reg.wptr] <= wr_data_in;
    end
  end

  a_full_refuse: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_valid_in && !wr_ready_out |=> st_reg.count <= $past(st_reg.count))
    else $error("fifo count grew while full");

  a_count_bounded: assert property (@(posedge clk_in) disable iff (srst_in)
    st_reg.count <= CNT_FULL)
    else $error("fifo count above depth");

  a_ready_tracks_room: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_ready_out == (st_reg.count < CNT_FULL))
    else $error("fifo ready disagrees with fill level");

  a_empty_no_pop: assert property (@(posedge clk_in) disable iff (srst_in)
    !rd_valid_out
    |=> $stable(st_reg.rptr))
    else $error("fifo read pointer moved while empty");

endmodule // rx_beat_fifo

module rx_range_hit #(
  parameter int DATA_W = rx_hit_pkg::DATA_W,
  parameter int DEPTH  = rx_hit_pkg::FIFO_DEPTH
) (
  input  wire logic                              clk_in,
  input  wire logic                              srst_in,
  input  wire logic                              root_port_mode_in,
  input  wire logic                              src_valid_in,
  output logic                                   src_ready_out,
  input  wire logic                              src_first_in,
  input  wire logic                              src_last_in,
  input  wire logic [DATA_W-1:0]                 src_data_in,
  input  wire rx_hit_pkg::range_decode_type      src_decode_in,
  input  wire logic [rx_hit_pkg::FUNC_W-1:0]     src_func_in,
  input  wire logic                              rx_sink_ready_in,
  output logic                                   rx_beat_valid_out,
  output logic                                   rx_packet_first_beat_out,
  output logic                                   rx_packet_last_beat_out,
  output logic      [DATA_W-1:0]                 rx_beat_data_out,
  output logic      [rx_hit_pkg::HIT_W-1:0]      rx_range_hit_out,
  output logic      [rx_hit_pkg::FUNC_W-1:0]     rx_range_func_out
);

  localparam int META_W = $bits(rx_hit_pkg::beat_meta_type);
  localparam int WORD_W = DATA_W + META_W;

  typedef struct packed {
    logic                          ready_d;
    logic [rx_hit_pkg::HIT_W-1:0]  pkt_hit;
    logic [rx_hit_pkg::FUNC_W-1:0] pkt_func;
    logic                          out_valid;
    rx_hit_pkg::beat_meta_type     out_meta;
    logic [DATA_W-1:0]             out_data;
    logic [rx_hit_pkg::HIT_W-1:0]  seen_hit;
    logic [rx_hit_pkg::FUNC_W-1:0] seen_func;
  } state_type;

  state_type                     st_reg;
  state_type                     st_next;
  logic [rx_hit_pkg::HIT_W-1:0]  ep_hit;
  logic [rx_hit_pkg::HIT_W-1:0]  rp_hit;
  logic [rx_hit_pkg::HIT_W-1:0]  enc_hit;
  rx_hit_pkg::beat_meta_type     in_meta;
  rx_hit_pkg::beat_meta_type     fifo_meta;
  logic [WORD_W-1:0]             fifo_wr_word;
  logic [WORD_W-1:0]             fifo_rd_word;
  logic                          fifo_ready;
  logic                          fifo_rd_valid;
  logic                          src_fire;
  logic                          pop;

  // Endpoint and root port encodings; unmapped positions stay zero.
  always_comb begin
    ep_hit = rx_hit_pkg::HIT_NONE;
    ep_hit[rx_hit_pkg::EP_BAR0_BIT +: rx_hit_pkg::EP_BAR_N] = src_decode_in.ep_bar;
    ep_hit[rx_hit_pkg::EP_ROM_BIT]  = src_decode_in.ep_rom;
    ep_hit[rx_hit_pkg::EP_RSVD_BIT] = 1'b0;
    rp_hit = rx_hit_pkg::HIT_NONE;
    rp_hit[rx_hit_pkg::RP_BAR0_BIT +: rx_hit_pkg::RP_BAR_N] = src_decode_in.rp_bar;
    rp_hit[rx_hit_pkg::RP_PRI_BIT] = src_decode_in.rp_primary_bus;
    rp_hit[rx_hit_pkg::RP_SEC_BIT] = src_decode_in.rp_secondary_bus;
    rp_hit[rx_hit_pkg::RP_BUS_BIT] = src_decode_in.rp_bus_window;
    rp_hit[rx_hit_pkg::RP_IO_BIT]  = src_decode_in.rp_io_window;
    rp_hit[rx_hit_pkg::RP_NP_BIT]  = src_decode_in.rp_np_window;
    rp_hit[rx_hit_pkg::RP_PF_BIT]  = src_decode_in.rp_pref_window;
  end

  // The mode is applied as beats enter the buffer. Beats already queued keep the encoding
  // they were taken with, so change the mode only while the buffer is empty.
  // Completions and messages carry no decode, so they report no hit.
  assign enc_hit = !src_decode_in.is_request ? rx_hit_pkg::HIT_NONE :
                   root_port_mode_in ? rp_hit : ep_hit;

  assign src_fire = src_valid_in && fifo_ready;

  // Later beats reuse the value taken on the first beat of the packet.
  always_comb begin
    in_meta.first = src_first_in;
    in_meta.last  = src_last_in;
    in_meta.hit   = src_first_in ? enc_hit : st_reg.pkt_hit;
    in_meta.func  = src_first_in ? src_func_in : st_reg.pkt_func;
  end

  assign fifo_wr_word = {in_meta, src_data_in};

  rx_beat_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .wr_valid_in  (src_valid_in),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (fifo_wr_word),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (pop),
    .rd_data_out  (fifo_rd_word)
  );

  assign fifo_meta = fifo_rd_word[WORD_W-1:DATA_W];

  // The sink sees a ready latency of two: a beat goes out only if ready
  // was high two cycles back, so every offered beat must be taken.
  assign pop = fifo_rd_valid && st_reg.ready_d;

  always_comb begin
    st_next = st_reg;
    st_next.ready_d = rx_sink_ready_in;
    if (src_fire && src_first_in) begin
      st_next.pkt_hit  = enc_hit;
      st_next.pkt_func = src_func_in;
    end
    st_next.out_valid = pop;
    if (pop) begin
      st_next.out_meta = fifo_meta;
      st_next.out_data = fifo_rd_word[DATA_W-1:0];
    end
    // Checking aid: hit and function of the last first beat that reached the pins.
    if (st_reg.out_valid && st_reg.out_meta.first) begin
      st_next.seen_hit  = st_reg.out_meta.hit;
      st_next.seen_func = st_reg.out_meta.func;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign src_ready_out            = fifo_ready;
  assign rx_beat_valid_out        = st_reg.out_valid;
  assign rx_packet_first_beat_out = st_reg.out_meta.first;
  assign rx_packet_last_beat_out  = st_reg.out_meta.last;
  assign rx_beat_data_out         = st_reg.out_data;
  assign rx_range_hit_out         = st_reg.out_meta.hit;
  assign rx_range_func_out        = st_reg.out_meta.func;

  a_ep_map_bits: assert property (@(posedge clk_in) disable iff (srst_in)
    src_fire && src_first_in && src_decode_in.is_request && !root_port_mode_in
    |=> st_reg.pkt_hit == {1'b0, $past(src_decode_in.ep_rom), $past(src_decode_in.ep_bar)})
    else $error("endpoint hit encoding wrong");

  a_rp_map_bits: assert property (@(posedge clk_in) disable iff (srst_in)
    src_fire && src_first_in && src_decode_in.is_request && root_port_mode_in
    |=> st_reg.pkt_hit == {$past(src_decode_in.rp_pref_window), $past(src_decode_in.rp_np_window),
                           $past(src_decode_in.rp_io_window), $past(src_decode_in.rp_bus_window),
                           $past(src_decode_in.rp_secondary_bus), $past(src_decode_in.rp_primary_bus),
                           $past(src_decode_in.rp_bar)})
    else $error("root port hit encoding wrong");

  a_nonreq_hit_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    src_fire && src_first_in && !src_decode_in.is_request |=> st_reg.pkt_hit == rx_hit_pkg::HIT_NONE)
    else $error("hit reported for completion or message");

  a_reserved_bit_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_beat_valid_out && !root_port_mode_in |-> !rx_range_hit_out[rx_hit_pkg::EP_RSVD_BIT])
    else $error("endpoint reserved hit bit set");

  a_hit_held_packet: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_beat_valid_out && !rx_packet_first_beat_out |-> rx_range_hit_out == st_reg.seen_hit)
    else $error("hit changed inside packet");

  a_func_held_packet: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_beat_valid_out && !rx_packet_first_beat_out |-> rx_range_func_out == st_reg.seen_func)
    else $error("function number changed inside packet");

  a_valid_drop_two: assert property (@(posedge clk_in) disable iff (srst_in)
    !rx_sink_ready_in |-> ##2 !rx_beat_valid_out)
    else $error("valid held after ready removed");

  a_valid_needs_ready: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_beat_valid_out |-> $past(rx_sink_ready_in, 2))
    else $error("beat offered without earlier ready");

  a_func_first_take: assert property (@(posedge clk_in) disable iff (srst_in)
    src_fire && src_first_in
    |=> st_reg.pkt_func == $past(src_func_in))
    else $error("function number not taken from first beat");

  a_later_beat_keep: assert property (@(posedge clk_in) disable iff (srst_in)
    src_fire && !src_first_in
    |=> $stable(st_reg.pkt_hit))
    else $error("later beat changed the packet hit");

  // A popped word reaches the pins one cycle later and then holds while no beat flows.
  a_out_follows_pop: assert property (@(posedge clk_in) disable iff (srst_in)
    pop
    |=> rx_beat_valid_out && rx_range_hit_out == $past(fifo_meta.hit))
    else $error("popped beat did not reach the outputs");

  a_idle_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    !pop
    |=> $stable(rx_range_hit_out) && $stable(rx_range_func_out))
    else $error("hit outputs moved without a beat");

endmodule // rx_range_hit

// ===== tb/rx_sink_model.sv
// Behavioural receive sink: paces ready and audits the beats it is offered.
`timescale 1ns/10ps

module rx_sink_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       stall_in,
  input  wire logic       slow_in,
  input  wire logic       beat_valid_in,
  input  wire logic       first_in,
  input  wire logic [7:0] hit_in,
  output logic            sink_ready_out,
  output int              faults_out
);
  logic [2:0] pace;
  logic [7:0] held_hit;
  logic       rdy_d1;
  logic       rdy_d2;

  initial begin
    pace = 3'h0;
    sink_ready_out = 1'b1;
  end

  // A slow sink drops ready in an irregular pattern so the latency window is hit at every phase.
  always @(negedge clk_in) begin
    pace <= pace + 3'h1;
    sink_ready_out <= !stall_in && (!slow_in || (pace[0] ^ pace[2]));
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      rdy_d1 <= 1'b0;
      rdy_d2 <= 1'b0;
      faults_out <= 0;
    end else begin
      rdy_d1 <= sink_ready_out;
      rdy_d2 <= rdy_d1;
      if (beat_valid_in && !rdy_d2) faults_out <= faults_out + 1;
      if (beat_valid_in && first_in) held_hit <= hit_in;
      else if (beat_valid_in && hit_in !== held_hit) faults_out <= faults_out + 1;
    end
  end
endmodule // rx_sink_model

// ===== tb/tb_rx_range_hit.sv
// Self-checking bench for the range-hit sideband stage.
`timescale 1ns/10ps

module tb_rx_range_hit;
  typedef struct packed {
    logic        first;
    logic        last;
    logic [7:0]  hit;
    logic [2:0]  func;
    logic [63:0] data;
  } note_type;

  logic                          clk_in = 1'b0;
  logic                          srst_in = 1'b1;
  logic                          root_port_mode_in = 1'b0;
  logic                          src_valid_in = 1'b0;
  logic                          src_first_in = 1'b0;
  logic                          src_last_in = 1'b0;
  logic [63:0]                   src_data_in = 64'h0;
  rx_hit_pkg::range_decode_type  src_decode_in = '0;
  logic [2:0]                    src_func_in = 3'h0;
  logic                          stall = 1'b0;
  logic                          slow = 1'b0;
  logic                          src_ready_out, rx_sink_ready_in, rx_beat_valid_out, first_out, last_out;
  logic [63:0]                   data_out;
  logic [7:0]                    hit_out;
  logic [2:0]                    func_out;
  logic [31:0]                   seed = 32'h63e8e0df;
  int                            faults, mismatches = 0, n_compared = 0, taken = 0, cycles = 0, w;
  note_type                      expq[$];
  note_type                      seen;

  always #5 clk_in = ~clk_in;

  rx_range_hit dut_u (.clk_in(clk_in), .srst_in(srst_in), .root_port_mode_in(root_port_mode_in),
    .src_valid_in(src_valid_in), .src_ready_out(src_ready_out), .src_first_in(src_first_in),
    .src_last_in(src_last_in), .src_data_in(src_data_in), .src_decode_in(src_decode_in),
    .src_func_in(src_func_in), .rx_sink_ready_in(rx_sink_ready_in), .rx_beat_valid_out(rx_beat_valid_out),
    .rx_packet_first_beat_out(first_out), .rx_packet_last_beat_out(last_out),
    .rx_beat_data_out(data_out), .rx_range_hit_out(hit_out), .rx_range_func_out(func_out));

  rx_sink_model sink_u (.clk_in(clk_in), .srst_in(srst_in), .stall_in(stall), .slow_in(slow),
    .beat_valid_in(rx_beat_valid_out), .first_in(first_out), .hit_in(hit_out),
    .sink_ready_out(rx_sink_ready_in), .faults_out(faults));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_hit(rx_hit_pkg::range_decode_type d);
    if (!d.is_request) return 8'h00;
    if (root_port_mode_in) return {d.rp_pref_window, d.rp_np_window, d.rp_io_window, d.rp_bus_window,
      d.rp_secondary_bus, d.rp_primary_bus, d.rp_bar};
    return {1'b0, d.ep_rom, d.ep_bar};
  endfunction

  task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Later beats carry fresh decode values on purpose: only the first beat may count.
  task automatic send_pkt(int n);
    logic [31:0] r;
    note_type    nt;
    int          k;
    r = xs();
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      src_valid_in = 1'b1;
      src_first_in = (i == 0);
      src_last_in = (i == n - 1);
      src_decode_in = (i == 0) ? {r[15:1], r[20] | r[21]} : 16'(xs());
      src_func_in = (i == 0) ? r[24:22] : 3'(xs());
      src_data_in = {xs(), xs()};
      if (i == 0) nt.hit = exp_hit(src_decode_in);
      nt.func = r[24:22];
      nt.first = (i == 0);
      nt.last = (i == n - 1);
      nt.data = src_data_in;
      k = 0;
      while (!src_ready_out && k < 1000) begin
        @(negedge clk_in);
        k++;
      end
      expq.push_back(nt);
      taken++;
    end
  endtask

  task automatic drain(string name);
    int k;
    @(negedge clk_in);
    src_valid_in = 1'b0;
    k = 0;
    while (expq.size() > 0 && k < 2000) begin
      @(negedge clk_in);
      k++;
    end
    repeat (4) @(negedge clk_in);
    cmp("beats left", 64'(0), 64'(expq.size()));
    cmp("sink faults", 64'(0), 64'(faults));
    $display("test %s finished", name);
  endtask

  always @(negedge clk_in) begin
    if (!srst_in && rx_beat_valid_out) begin
      if (expq.size() == 0) cmp("extra beat", 64'(0), 64'(1));
      else begin
        seen = expq.pop_front();
        cmp("first flag", 64'(seen.first), 64'(first_out));
        cmp("last flag", 64'(seen.last), 64'(last_out));
        cmp("range hit", 64'(seen.hit), 64'(hit_out));
        cmp("function", 64'(seen.func), 64'(func_out));
        cmp("data", seen.data, data_out);
      end
    end
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    cmp("ready after reset", 64'(1), 64'(src_ready_out));
    for (int m = 0; m < 2; m++) begin
      root_port_mode_in = m[0];
      for (int p = 0; p < 40; p++) begin
        slow = p[3];
        send_pkt(1 + p % 4);
      end
      drain(m ? "root port" : "endpoint");
    end
    // Stall the sink so the buffer fills to its limit, then let it drain.
    stall = 1'b1;
    repeat (3) @(negedge clk_in);
    taken = 0;
    fork
      send_pkt(40);
      begin
        w = 0;
        while (src_ready_out && w < 500) begin
          @(negedge clk_in);
          w++;
        end
        cmp("fill level", 64'(rx_hit_pkg::FIFO_DEPTH), 64'(taken));
        repeat (5) @(negedge clk_in);
        stall = 1'b0;
      end
    join
    drain("fill");
    give_verdict();
  end
endmodule // tb_rx_range_hit
